// *** pel_pkg.sv ***
// constants shared by the per-port error log block
// Notes on behaviour
// (R1) An unmasked non-fatal uncorrectable or correctable error sets its bit in the first non-fatal/correctable log.
// (R2) A bit of the first non-fatal/correctable log is only written while it is clear, so a first record is never overwritten.
// (R3) Each uncorrectable error goes to the fatal or the non-fatal logs by its own severity select bit; south-link reset timeout is always fatal.
// (R4) Correctable bits sit at receiver error 11, bad TLP 12, bad DLLP 13, replay rollover 14, replay timeout 15, correctable message 16.
// (R5) Non-fatal bits sit at DL protocol 0, UR 1, poisoned 3, flow control 4, completion timeout 5, completer abort 6, unexpected completion 7, malformed 8, overflow 9, non-fatal message 10, surprise down 17, with 31:18 reserved.
// (R6) A later unmasked fatal error sets its next-fatal bit only while the same bit is already set in the first-fatal log.
// (R7) Next-fatal bits sit at DL protocol 0, fatal message 1, UR 2, poisoned 4, flow control 5, completion timeout 6, completer abort 7, unexpected completion 8, overflow 9, malformed 10, south-link reset timeout 11, surprise down 12, with 31:13 reserved.
// (R8) Software must not rely on or set severity for the training error bit, whose hardware behaviour is undefined.
// (R9) The first-fatal log records the first unmasked fatal error of each type, writing a bit only while it is clear.
// (R10) Log bits reset to zero, clear only when software writes a one, and ignore written zeros.
package pel_pkg;

  // ***************************************************
  // register offsets and widths
  // ***************************************************
  localparam logic [11:0] OFS_FIRST_FATAL = 12'h154;
  localparam logic [11:0] OFS_FIRST_NF_COR = 12'h158;
  localparam logic [11:0] OFS_NEXT_FATAL = 12'h15c;
  localparam int FAT_W = 13;
  localparam int NF_W = 18;
  localparam int EV_W = 20;
  localparam logic [31:0] LOG_RESET = 32'h0000_0000;

  // ***************************************************
  // error event indices on the event input vector
  // ***************************************************
  localparam int EV_DLP = 0;
  localparam int EV_FAT_MSG = 1;
  localparam int EV_UR = 2;
  localparam int EV_TRAIN = 3;
  localparam int EV_POISON = 4;
  localparam int EV_FC = 5;
  localparam int EV_CTO = 6;
  localparam int EV_CA = 7;
  localparam int EV_UC = 8;
  localparam int EV_MTLP = 9;
  localparam int EV_ROVF = 10;
  localparam int EV_NF_MSG = 11;
  localparam int EV_RXERR = 12;
  localparam int EV_BAD_TLP = 13;
  localparam int EV_BAD_DLLP = 14;
  localparam int EV_RNUM = 15;
  localparam int EV_RTMR = 16;
  localparam int EV_COR_MSG = 17;
  localparam int EV_SL_RST = 18;
  localparam int EV_SLD = 19;

  // ***************************************************
  // fatal log bit positions (first and next fatal)
  // ***************************************************
  localparam int FB_DLP = 0;
  localparam int FB_FAT_MSG = 1;
  localparam int FB_UR = 2;
  localparam int FB_TRAIN = 3;
  localparam int FB_POISON = 4;
  localparam int FB_FC = 5;
  localparam int FB_CTO = 6;
  localparam int FB_CA = 7;
  localparam int FB_UC = 8;
  localparam int FB_ROVF = 9;
  localparam int FB_MTLP = 10;
  localparam int FB_SL_RST = 11;
  localparam int FB_SLD = 12;

  // ***************************************************
  // first non-fatal/correctable log bit positions
  // ***************************************************
  localparam int NB_DLP = 0;
  localparam int NB_UR = 1;
  localparam int NB_TRAIN = 2;
  localparam int NB_POISON = 3;
  localparam int NB_FC = 4;
  localparam int NB_CTO = 5;
  localparam int NB_CA = 6;
  localparam int NB_UC = 7;
  localparam int NB_MTLP = 8;
  localparam int NB_ROVF = 9;
  localparam int NB_NF_MSG = 10;
  localparam int NB_RXERR = 11;
  localparam int NB_BAD_TLP = 12;
  localparam int NB_BAD_DLLP = 13;
  localparam int NB_RNUM = 14;
  localparam int NB_RTMR = 15;
  localparam int NB_COR_MSG = 16;
  localparam int NB_SLD = 17;

endpackage

// *** pel_sticky_log.sv ***
// sticky write-one-to-clear log with gated first-occurrence capture
module pel_sticky_log #(
  parameter int W = 13
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // hardware capture
  input wire logic [W-1:0] set_vec,
  input wire logic [W-1:0] gate_vec,
  // software clear, one bit per log bit
  input wire logic [W-1:0] clr_vec,
  // log contents
  output logic [W-1:0] log_q
);

  logic [W-1:0] log_ff;
  logic [W-1:0] nxt_log;

  // (R10) clear by ones only
  // a set arriving with its clear wins, so no event is lost
  always_comb
  begin
    nxt_log = (log_ff & ~clr_vec) | (set_vec & gate_vec);
  end

  // log flops, zero after reset
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      log_ff <= '0;
    end
    else
    begin
      log_ff <= nxt_log;
    end
  end

  assign log_q = log_ff;

endmodule

// *** pel_port_error_log.sv ***
// per-port error log registers for one express root port
module pel_port_error_log #(
  parameter int EVN = pel_pkg::EV_W
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // configuration register access
  input wire logic [11:0] cfg_addr,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  // error detection from the link, transaction and data-link layers
  input wire logic [EVN-1:0] err_evt,
  input wire logic [EVN-1:0] err_mask,
  input wire logic [EVN-1:0] sev_fatal,
  // summary levels
  output logic fatal_logged,
  output logic nonfatal_cor_logged
);

  // ***************************************************
  // event mapping functions
  // ***************************************************

  // fatal-class events onto the fatal log layout
  // (R7) next-fatal layout
  function automatic logic [pel_pkg::FAT_W-1:0] map_fatal(input logic [EVN-1:0] ev);
    logic [pel_pkg::FAT_W-1:0] v;
    v = '0;
    v[pel_pkg::FB_DLP] = ev[pel_pkg::EV_DLP];
    v[pel_pkg::FB_FAT_MSG] = ev[pel_pkg::EV_FAT_MSG];
    v[pel_pkg::FB_UR] = ev[pel_pkg::EV_UR];
    v[pel_pkg::FB_TRAIN] = ev[pel_pkg::EV_TRAIN];
    v[pel_pkg::FB_POISON] = ev[pel_pkg::EV_POISON];
    v[pel_pkg::FB_FC] = ev[pel_pkg::EV_FC];
    v[pel_pkg::FB_CTO] = ev[pel_pkg::EV_CTO];
    v[pel_pkg::FB_CA] = ev[pel_pkg::EV_CA];
    v[pel_pkg::FB_UC] = ev[pel_pkg::EV_UC];
    v[pel_pkg::FB_ROVF] = ev[pel_pkg::EV_ROVF];
    v[pel_pkg::FB_MTLP] = ev[pel_pkg::EV_MTLP];
    v[pel_pkg::FB_SL_RST] = ev[pel_pkg::EV_SL_RST];
    v[pel_pkg::FB_SLD] = ev[pel_pkg::EV_SLD];
    return v;
  endfunction

  // non-fatal and correctable events onto the first non-fatal layout
  // (R4) correctable bit places
  // (R5) non-fatal bit places
  function automatic logic [pel_pkg::NF_W-1:0] map_nf_cor(input logic [EVN-1:0] ev);
    logic [pel_pkg::NF_W-1:0] v;
    v = '0;
    v[pel_pkg::NB_DLP] = ev[pel_pkg::EV_DLP];
    v[pel_pkg::NB_UR] = ev[pel_pkg::EV_UR];
    v[pel_pkg::NB_TRAIN] = ev[pel_pkg::EV_TRAIN];
    v[pel_pkg::NB_POISON] = ev[pel_pkg::EV_POISON];
    v[pel_pkg::NB_FC] = ev[pel_pkg::EV_FC];
    v[pel_pkg::NB_CTO] = ev[pel_pkg::EV_CTO];
    v[pel_pkg::NB_CA] = ev[pel_pkg::EV_CA];
    v[pel_pkg::NB_UC] = ev[pel_pkg::EV_UC];
    v[pel_pkg::NB_MTLP] = ev[pel_pkg::EV_MTLP];
    v[pel_pkg::NB_ROVF] = ev[pel_pkg::EV_ROVF];
    v[pel_pkg::NB_NF_MSG] = ev[pel_pkg::EV_NF_MSG];
    v[pel_pkg::NB_RXERR] = ev[pel_pkg::EV_RXERR];
    v[pel_pkg::NB_BAD_TLP] = ev[pel_pkg::EV_BAD_TLP];
    v[pel_pkg::NB_BAD_DLLP] = ev[pel_pkg::EV_BAD_DLLP];
    v[pel_pkg::NB_RNUM] = ev[pel_pkg::EV_RNUM];
    v[pel_pkg::NB_RTMR] = ev[pel_pkg::EV_RTMR];
    v[pel_pkg::NB_COR_MSG] = ev[pel_pkg::EV_COR_MSG];
    v[pel_pkg::NB_SLD] = ev[pel_pkg::EV_SLD];
    return v;
  endfunction

  // write-one clear mask for one register, honouring byte lanes
  function automatic logic [31:0] clr_word(
    input logic [11:0] addr,
    input logic [11:0] ofs,
    input logic wr,
    input logic [3:0] be,
    input logic [31:0] wd
  );
    logic [31:0] m;
    m = '0;
    if (wr && (addr == ofs))
    begin
      m = wd & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    end
    return m;
  endfunction

  // ***************************************************
  // classification
  // ***************************************************

  logic [EVN-1:0] unmasked;
  logic [EVN-1:0] fat_class;
  logic [EVN-1:0] nf_class;
  logic [pel_pkg::FAT_W-1:0] fat_hits;
  logic [pel_pkg::NF_W-1:0] nf_hits;

  // split unmasked events by severity; messages carry their own class
  // (R3) severity routing
  always_comb
  begin
    unmasked = err_evt & ~err_mask;
    fat_class = sev_fatal;
    fat_class[pel_pkg::EV_FAT_MSG] = 1'b1;
    fat_class[pel_pkg::EV_NF_MSG] = 1'b0;
    fat_class[pel_pkg::EV_RXERR] = 1'b0;
    fat_class[pel_pkg::EV_BAD_TLP] = 1'b0;
    fat_class[pel_pkg::EV_BAD_DLLP] = 1'b0;
    fat_class[pel_pkg::EV_RNUM] = 1'b0;
    fat_class[pel_pkg::EV_RTMR] = 1'b0;
    fat_class[pel_pkg::EV_COR_MSG] = 1'b0;
    // south-link reset timeout has no non-fatal home
    fat_class[pel_pkg::EV_SL_RST] = 1'b1;
    nf_class = ~fat_class;
    fat_hits = map_fatal(unmasked & fat_class);
    nf_hits = map_nf_cor(unmasked & nf_class);
  end

  // ***************************************************
  // software clears
  // ***************************************************

  logic [31:0] clr_ff_word;
  logic [31:0] clr_nf_word;
  logic [31:0] clr_nx_word;

  // reserved bits of a write are simply dropped below
  // (R10) ones clear, zeros ignored
  always_comb
  begin
    clr_ff_word = clr_word(cfg_addr, pel_pkg::OFS_FIRST_FATAL, cfg_wr, cfg_be, cfg_wdata);
    clr_nf_word = clr_word(cfg_addr, pel_pkg::OFS_FIRST_NF_COR, cfg_wr, cfg_be, cfg_wdata);
    clr_nx_word = clr_word(cfg_addr, pel_pkg::OFS_NEXT_FATAL, cfg_wr, cfg_be, cfg_wdata);
  end

  // ***************************************************
  // the three logs
  // ***************************************************

  logic [pel_pkg::FAT_W-1:0] first_fatal_error_log;
  logic [pel_pkg::NF_W-1:0] first_nonfatal_correctable_error_log;
  logic [pel_pkg::FAT_W-1:0] next_fatal_error_log;

  // first fatal: capture only into clear bits; a bit cleared this cycle
  // counts as clear, so a set arriving with its clear still lands
  // (R9) first fatal capture
  pel_sticky_log #(
    .W(pel_pkg::FAT_W)
  ) u_first_fatal (
    .mclk(mclk),
    .nrst(nrst),
    .set_vec(fat_hits),
    .gate_vec(~first_fatal_error_log | clr_ff_word[pel_pkg::FAT_W-1:0]),
    .clr_vec(clr_ff_word[pel_pkg::FAT_W-1:0]),
    .log_q(first_fatal_error_log)
  );

  // first non-fatal/correctable: capture only into clear bits
  // (R1) non-fatal and correctable capture
  // (R2) first record kept
  pel_sticky_log #(
    .W(pel_pkg::NF_W)
  ) u_first_nf_cor (
    .mclk(mclk),
    .nrst(nrst),
    .set_vec(nf_hits),
    .gate_vec(~first_nonfatal_correctable_error_log | clr_nf_word[pel_pkg::NF_W-1:0]),
    .clr_vec(clr_nf_word[pel_pkg::NF_W-1:0]),
    .log_q(first_nonfatal_correctable_error_log)
  );

  // next fatal: gated by the current first-fatal bit, so an event that fills a bit clear
  // before this edge does not also land here; one arriving with its first-fatal clear lands in both
  // (R6) next fatal gating
  pel_sticky_log #(
    .W(pel_pkg::FAT_W)
  ) u_next_fatal (
    .mclk(mclk),
    .nrst(nrst),
    .set_vec(fat_hits),
    .gate_vec(first_fatal_error_log),
    .clr_vec(clr_nx_word[pel_pkg::FAT_W-1:0]),
    .log_q(next_fatal_error_log)
  );

  // ***************************************************
  // register read path
  // ***************************************************

  logic [31:0] rdata_ff;
  logic rvalid_ff;
  logic [31:0] nxt_rdata;

  // reserved bits and unmapped offsets read as zero
  // (R5) reserved upper bits
  // (R7) reserved upper bits
  always_comb
  begin
    nxt_rdata = '0;
    case (cfg_addr)
      pel_pkg::OFS_FIRST_FATAL:
        nxt_rdata[pel_pkg::FAT_W-1:0] = first_fatal_error_log;
      pel_pkg::OFS_FIRST_NF_COR:
        nxt_rdata[pel_pkg::NF_W-1:0] = first_nonfatal_correctable_error_log;
      pel_pkg::OFS_NEXT_FATAL:
        nxt_rdata[pel_pkg::FAT_W-1:0] = next_fatal_error_log;
      default:
        nxt_rdata = '0;
    endcase
  end

  // read data is the log as it stood at the request edge
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_ff <= pel_pkg::LOG_RESET;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rvalid_ff <= cfg_rd;
      if (cfg_rd)
      begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  // ***************************************************
  // summary levels
  // ***************************************************

  logic fat_any_ff;
  logic nf_any_ff;

  // registered so outputs stay glitch free; lag the logs by one cycle
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      fat_any_ff <= 1'b0;
      nf_any_ff <= 1'b0;
    end
    else
    begin
      fat_any_ff <= |first_fatal_error_log;
      nf_any_ff <= |first_nonfatal_correctable_error_log;
    end
  end

  assign cfg_rdata = rdata_ff;
  assign cfg_rvalid = rvalid_ff;
  assign fatal_logged = fat_any_ff;
  assign nonfatal_cor_logged = nf_any_ff;

endmodule

// *** pel_port_error_log_props.sv ***
// port-level assertions for the per-port error log
module pel_port_error_log_props #(
  parameter int EVN = pel_pkg::EV_W
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // register access
  input wire logic [11:0] cfg_addr,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_rvalid,
  // error events and summaries
  input wire logic [EVN-1:0] err_evt,
  input wire logic [EVN-1:0] err_mask,
  input wire logic [EVN-1:0] sev_fatal,
  input wire logic fatal_logged,
  input wire logic nonfatal_cor_logged
);
  // ****************************************
  // sequences and checks
  // ****************************************
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  // events that get past the detect mask
  wire logic [EVN-1:0] live = err_evt & ~err_mask;
  sequence rd_at(logic [11:0] a);
    cfg_rd && cfg_addr == a;
  endsequence
  sequence quiet;
    ~|live;
  endsequence
  rvalid_pulse_a: assert property (1'b1 |=> cfg_rvalid == $past(cfg_rd))
    else $error("read answer pulse wrong");
  rdata_hold_a: assert property (!cfg_rd |=> $stable(cfg_rdata))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (cfg_rd && !(cfg_addr inside {12'h154, 12'h158,
    12'h15c}) |=> cfg_rdata == 32'h0)
    else $error("unmapped read not zero");
  nf_reserved_a: assert property (rd_at(12'h158) |=> cfg_rdata[31:18] == 14'h0)
    else $error("reserved nf bits set");
  nx_reserved_a: assert property (rd_at(12'h15c) |=> cfg_rdata[31:13] == 19'h0)
    else $error("reserved next-fatal bits set");
  cor_logged_a: assert property (live[12] |-> ##2 nonfatal_cor_logged)
    else $error("correctable event not logged");
  nf_route_a: assert property (live[6] && !sev_fatal[6] |-> ##2 nonfatal_cor_logged)
    else $error("non-fatal event not logged");
  fatal_route_a: assert property (live[1] |-> ##2 fatal_logged)
    else $error("fatal message not logged");
  nf_sticky_a: assert property (nonfatal_cor_logged && !cfg_wr && !$past(cfg_wr)
    |=> nonfatal_cor_logged)
    else $error("log dropped without a clear");
  quiet_idle_a: assert property (quiet ##1 (quiet and !fatal_logged) |=> !fatal_logged)
    else $error("fatal log set with no event");
endmodule
bind pel_port_error_log pel_port_error_log_props #(.EVN(EVN)) u_props (
  .mclk, .nrst, .cfg_addr, .cfg_wr, .cfg_rd, .cfg_be, .cfg_wdata, .cfg_rdata,
  .cfg_rvalid, .err_evt, .err_mask, .sev_fatal, .fatal_logged, .nonfatal_cor_logged
);

// *** pel_err_src.sv ***
// stand-in for the port's layer error detection logic
module pel_err_src (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // detect pulses, masks and severity
  output logic [19:0] err_evt,
  output logic [19:0] err_mask,
  output logic [19:0] sev_fatal
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // driving tasks
  // ****************************************
  // quiet at time zero
  initial
  begin
    err_evt = '0;
    err_mask = '0;
    sev_fatal = '0;
  end
  // severity and mask are levels, set before pulses
  task automatic set_cfg(input logic [19:0] m, input logic [19:0] s);
    @(posedge mclk);
    err_mask <= m;
    sev_fatal <= s;
  endtask
  // one-cycle pulses, two back to back, after an optional stall
  task automatic fire(input logic [19:0] v1, input logic [19:0] v2, input int gap);
    repeat (gap) @(posedge mclk);
    @(posedge mclk);
    err_evt <= v1;
    @(posedge mclk);
    err_evt <= v2;
    @(posedge mclk);
    err_evt <= '0;
  endtask
endmodule

// *** pel_port_error_log_tb.sv ***
// self-checking bench for the per-port error log
module pel_port_error_log_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, nrst, cfg_wr, cfg_rd, cfg_rvalid, fatal_logged, nonfatal_cor_logged;
  logic [11:0] cfg_addr;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, m_ff, m_nf, m_nx;
  logic [19:0] err_evt, err_mask, sev_fatal, msk, sev;
  logic [43:0] notes[$];
  logic [43:0] nt;
  int errors = 0;
  int comparisons = 0;
  // event index to first/next fatal bit and to nf/cor bit, -1 where none
  int fb[20] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 10, 9, -1, -1, -1, -1, -1, -1, -1, 11, 12};
  int nb[20] = '{0, -1, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16, -1, 17};
  // 40 MHz core clock
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  pel_port_error_log u_pel_port_error_log (.mclk, .nrst, .cfg_addr, .cfg_wr, .cfg_rd,
    .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_rvalid, .err_evt, .err_mask, .sev_fatal,
    .fatal_logged, .nonfatal_cor_logged);
  pel_err_src u_pel_err_src (.mclk, .nrst, .err_evt, .err_mask, .sev_fatal);
  // ****************************************
  // model and bus tasks
  // ****************************************
  // next-fatal looks at the first-fatal bit before it is set
  function automatic void apply(input logic [19:0] x);
    for (int i = 0; i < 20; i++)
      if (x[i] && !msk[i])
      begin
        if (i == 1 || i == 18 || ((i < 11 || i == 19) && sev[i]))
        begin
          if (m_ff[fb[i]]) m_nx[fb[i]] = 1'b1;
          m_ff[fb[i]] = 1'b1;
        end
        else
          m_nf[nb[i]] = 1'b1;
      end
  endfunction
  task automatic hit(input logic [19:0] v1, input logic [19:0] v2, input int gap);
    u_pel_err_src.fire(v1, v2, gap);
    apply(v1);
    apply(v2);
  endtask
  task automatic cfg(input logic [19:0] m, input logic [19:0] s);
    msk = m;
    sev = s;
    u_pel_err_src.set_cfg(m, s);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge mclk);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    notes.push_back({a, e});
    @(posedge mclk);
    cfg_rd <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
    logic [31:0] cm;
    @(posedge mclk);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_be <= be;
    cfg_wdata <= d;
    @(posedge mclk);
    cfg_wr <= 1'b0;
    cm = d & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    if (a == 12'h154) m_ff &= ~cm;
    if (a == 12'h158) m_nf &= ~cm;
    if (a == 12'h15c) m_nx &= ~cm;
  endtask
  task automatic chk_all;
    rd(12'h154, m_ff);
    rd(12'h158, m_nf);
    rd(12'h15c, m_nx);
  endtask
  // oldest note against each read answer
  always @(posedge mclk)
    if (cfg_rvalid === 1'b1)
    begin
      comparisons++;
      nt = notes.pop_front();
      if (cfg_rdata !== nt[31:0])
      begin
        errors++;
        $display("Error rdata at %h expected %h seen %h", nt[43:32], nt[31:0], cfg_rdata);
      end
      // summaries lag the logs by one edge, so they match the read snapshot here
      if (nt[43:32] == 12'h154)
      begin
        comparisons++;
        if (fatal_logged !== (|nt[12:0]))
        begin
          errors++;
          $display("Error fatal_logged expected %b seen %b", |nt[12:0], fatal_logged);
        end
      end
      if (nt[43:32] == 12'h158)
      begin
        comparisons++;
        if (nonfatal_cor_logged !== (|nt[17:0]))
        begin
          errors++;
          $display("Error nonfatal_cor_logged expected %b seen %b", |nt[17:0],
            nonfatal_cor_logged);
        end
      end
    end
  task automatic wrap_up;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    int i;
    {nrst, cfg_wr, cfg_rd, cfg_be, cfg_addr, cfg_wdata} = '0;
    {m_ff, m_nf, m_nx, msk, sev} = '0;
    void'($urandom(90));
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    chk_all();
    rd(12'h150, 32'h0);
    // every event alone, training event never raised
    for (i = 0; i < 20; i++)
      if (i != 3) hit(20'h1 << i, 20'h0, i % 3);
    chk_all();
    hit(20'hffff7, 20'hffff7, 0);
    chk_all();
    // no lanes, zeros and an unmapped write leave bits alone; the lane 1 write and the 0x800 write to 154 clear bits
    wr(12'h158, 4'h0, 32'hffff_ffff);
    wr(12'h158, 4'hf, 32'h0);
    wr(12'h158, 4'h2, 32'hffff_ffff);
    wr(12'h154, 4'hf, 32'h0000_0800);
    wr(12'h150, 4'hf, 32'hffff_ffff);
    chk_all();
    // random masks, severities and back-to-back bursts
    for (i = 0; i < 8; i++)
    begin
      cfg(20'($urandom), 20'($urandom));
      hit(20'($urandom) & 20'hffff7, 20'($urandom) & 20'hffff7, i % 4);
      chk_all();
      wr(12'h154 + 12'(4 * (i % 3)), 4'hf, $urandom);
    end
    chk_all();
    i = 0;
    while (notes.size() != 0 && i < 20)
    begin
      @(posedge mclk);
      i++;
    end
    if (notes.size() != 0) errors++;
    wrap_up();
  end
endmodule
